// ### hdl/qfd_top.sv
`timescale 1ns/1ps
`include "qfd_consts.svh"

// Overview of operation
// - Both encoder channels are sampled on every rising clock edge and filtered identically and independently.
// - Each channel keeps its recent samples in a four-stage shift register that feeds the filter decision.
// - A filtered channel changes only after three consecutive samples show the new level.
// - Spikes between clock edges and pulses shorter than two clock periods leave the filtered output unchanged.
// - The decoder counts in 4x mode, once for each edge of either channel.
// - The previous and present filtered pair are compared each clock to give a count strobe and a direction.
// - Every transition between adjacent quadrature states gives exactly one count strobe, up or down.
// - The first channel leading gives count up and the second channel leading gives count down.
// - State 1 is first high second low, state 2 both high, state 3 first low second high, state 4 both low.
// - Illegal jumps such as both channels changing at once are not flagged.
// - The position counter steps on a rising clock edge according to the strobe and direction.
// - An input change accepted by the filter reaches the counter within seven clock periods.
// - Each count appears outside as a half-clock-wide pulse in the cycle in which the counter updates.
// - The direction output is high for up and low for down and is settled before the count pulse rises.

module qfd_top
#(
  parameter int CNT_W = `QFD_CNT_W
)
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             encoder_input_first_i,
  input  wire logic             encoder_input_second_i,
  output logic                  decode_count_pulse_o,
  output logic                  count_up_o,
  output logic [CNT_W-1:0]      position_o
);

  // ********************************************************
  // Quadrature state number, zero based.
  // ********************************************************
  function automatic logic [1:0] qfd_state_num(input logic first, input logic second);
    logic [1:0] num;
    begin
      num = 2'h0;
      case ({first, second})
        2'b10:   num = 2'h0;
        2'b11:   num = 2'h1;
        2'b01:   num = 2'h2;
        2'b00:   num = 2'h3;
        default: num = 2'h3;
      endcase
      return num;
    end
  endfunction

  // ********************************************************
  // Step between two state numbers.
  // ********************************************************
  function automatic qfd_pkg::qfd_step_type qfd_step(input logic [1:0] from, input logic [1:0] to);
    qfd_pkg::qfd_step_type step;
    begin
      step = qfd_pkg::QFD_HOLD;
      if (to == from + 2'h1)
      begin
        step = qfd_pkg::QFD_UP;
      end
      else if (from == to + 2'h1)
      begin
        step = qfd_pkg::QFD_DOWN;
      end
      return step;
    end
  endfunction

  qfd_pkg::qfd_top_type  st_r;
  qfd_pkg::qfd_top_type  st_nxt;
  qfd_pkg::qfd_step_type step;
  logic                  filt_first;
  logic                  filt_second;
  logic [1:0]            now_state;

  // ********************************************************
  // Channel filters.
  // ********************************************************
  qfd_filter
  #(
    .HIST_W   (`QFD_HIST_W),
    .STABLE_N (`QFD_STABLE_N)
  )
  u_filt_first
  (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sample_i (st_r.sync2[1]),
    .level_o  (filt_first)
  );

  qfd_filter
  #(
    .HIST_W   (`QFD_HIST_W),
    .STABLE_N (`QFD_STABLE_N)
  )
  u_filt_second
  (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sample_i (st_r.sync2[0]),
    .level_o  (filt_second)
  );

  // ********************************************************
  // Decoder and position counter.
  // ********************************************************
  always_comb
  begin
    now_state = qfd_state_num(filt_first, filt_second);
    step      = qfd_step(st_r.prev, now_state);
  end

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.sync1 = {encoder_input_first_i, encoder_input_second_i};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = now_state;
    st_nxt.pulse = 1'b0;
    case (step)
      qfd_pkg::QFD_UP:
      begin
        st_nxt.pulse = 1'b1;
        st_nxt.dir   = 1'b1;
        st_nxt.count = st_r.count + 16'h0001;
      end
      qfd_pkg::QFD_DOWN:
      begin
        st_nxt.pulse = 1'b1;
        st_nxt.dir   = 1'b0;
        st_nxt.count = st_r.count - 16'h0001;
      end
      default:
      begin
        st_nxt.pulse = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_r       <= '0;
      st_r.prev  <= `QFD_STATE_RST;
      st_r.dir   <= 1'b1;
      st_r.count <= `QFD_CNT_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************
  // Outputs.
  // ********************************************************
  assign decode_count_pulse_o = st_r.pulse & ~clk_i;
  assign count_up_o           = st_r.dir;
  assign position_o           = st_r.count[CNT_W-1:0];

  // ********************************************************
  // Checks.
  // ********************************************************
  sample_path_a : assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i, 2) |-> st_r.sync2 == $past({encoder_input_first_i, encoder_input_second_i}, 2))
    else $error("Channel samples did not reach the filters.");

  no_move_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (st_r.prev == now_state) |=> !st_r.pulse && $stable(st_r.count))
    else $error("Count produced without a state change.");

  strobe_move_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (now_state == st_r.prev + 2'h1 || st_r.prev == now_state + 2'h1) |=> st_r.pulse)
    else $error("Adjacent transition gave no count.");

  illegal_jump_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (now_state == st_r.prev + 2'h2) |=> !st_r.pulse)
    else $error("Illegal jump produced a count.");

  dir_up_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (st_r.prev == 2'h3 && now_state == 2'h0) |=> st_r.pulse && st_r.dir)
    else $error("First channel leading did not count up.");

  dir_down_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (st_r.prev == 2'h0 && now_state == 2'h3) |=> st_r.pulse && !st_r.dir)
    else $error("Second channel leading did not count down.");

  state_code_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (filt_first && !filt_second) |-> now_state == 2'h0)
    else $error("State one encoded wrongly.");

  count_step_a : assert property (@(posedge clk_i) disable iff (srst_i)
    st_r.pulse && !$past(srst_i) |->
      st_r.count == (st_r.dir ? $past(st_r.count) + 16'h0001 : $past(st_r.count) - 16'h0001))
    else $error("Counter did not step with the strobe.");

  count_hold_a : assert property (@(posedge clk_i) disable iff (srst_i)
    !st_r.pulse && !$past(srst_i) |-> $stable(st_r.count))
    else $error("Counter moved without a strobe.");

  latency_a : assert property (@(posedge clk_i) disable iff (srst_i)
    $changed(filt_first) && !$past(srst_i, 6) |-> $past(encoder_input_first_i, 5) == filt_first)
    else $error("Filtered level does not follow the pin in time.");

  reset_clear_a : assert property (@(posedge clk_i)
    srst_i |=> !st_r.pulse && st_r.count == `QFD_CNT_RST && st_r.prev == `QFD_STATE_RST)
    else $error("Reset did not clear the decoder.");

  release_quiet_a : assert property (@(posedge clk_i)
    $fell(srst_i) |-> !st_r.pulse ##1 !st_r.pulse)
    else $error("Count produced on reset release.");

  pulse_half_a : assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) |-> decode_count_pulse_o == $changed(st_r.count))
    else $error("Count pulse not in the cycle of the counter update.");

  pulse_high_half_a : assert property (@(negedge clk_i) disable iff (srst_i)
    !decode_count_pulse_o)
    else $error("Count pulse high in the high half of the clock.");

  dir_settled_a : assert property (@(posedge clk_i) disable iff (srst_i)
    st_r.pulse && !$past(srst_i) |->
      count_up_o == (st_r.count == $past(st_r.count) + 16'h0001))
    else $error("Direction wrong while the count pulse stood.");

  dir_hold_a : assert property (@(posedge clk_i) disable iff (srst_i)
    !st_r.pulse && !$past(srst_i) |-> $stable(count_up_o))
    else $error("Direction changed without a count.");

  sync_first_a : assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) |-> st_r.sync1 == $past({encoder_input_first_i, encoder_input_second_i}))
    else $error("First sync stage missed a pin sample.");

  sync_chain_a : assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) |-> st_r.sync2 == $past(st_r.sync1))
    else $error("Second sync stage did not follow the first.");

  reset_filters_a : assert property (@(posedge clk_i)
    srst_i |=> !filt_first && !filt_second)
    else $error("Reset did not clear the filtered levels.");

  reset_dir_a : assert property (@(posedge clk_i)
    srst_i |=> count_up_o && !decode_count_pulse_o)
    else $error("Reset did not clear the outputs.");

  prev_track_a : assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) |-> st_r.prev == $past(now_state))
    else $error("Stored state did not follow the filtered pair.");

  up_step_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (now_state == st_r.prev + 2'h1) |=>
      st_r.dir && st_r.count == $past(st_r.count) + 16'h0001)
    else $error("Forward step did not count up.");

  down_step_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (st_r.prev == now_state + 2'h1) |=>
      !st_r.dir && st_r.count == $past(st_r.count) - 16'h0001)
    else $error("Backward step did not count down.");

  single_strobe_a : assert property (@(posedge clk_i) disable iff (srst_i)
    st_r.pulse && !$past(srst_i) |->
      $past(now_state) != $past(st_r.prev))
    else $error("Count strobe without a state change.");

  four_x_a : assert property (@(posedge clk_i) disable iff (srst_i)
    ($changed(filt_first) != $changed(filt_second)) && !$past(srst_i) |=>
      st_r.pulse)
    else $error("Edge of one channel gave no count.");

  jump_hold_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (now_state == st_r.prev + 2'h2) |=> $stable(st_r.count) && $stable(st_r.dir))
    else $error("Illegal jump moved the counter.");

  state_two_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (filt_first && filt_second) |-> now_state == 2'h1)
    else $error("State two encoded wrongly.");

  state_three_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (!filt_first && filt_second) |-> now_state == 2'h2)
    else $error("State three encoded wrongly.");

  state_four_a : assert property (@(posedge clk_i) disable iff (srst_i)
    (!filt_first && !filt_second) |-> now_state == 2'h3)
    else $error("State four encoded wrongly.");

  latency_second_a : assert property (@(posedge clk_i) disable iff (srst_i)
    $changed(filt_second) && !$past(srst_i, 6) |-> $past(encoder_input_second_i, 5) == filt_second)
    else $error("Second filtered level does not follow the pin in time.");

  count_up_c : cover property (@(posedge clk_i) disable iff (srst_i)
    st_r.pulse && st_r.dir ##1 st_r.pulse && st_r.dir);

  count_down_c : cover property (@(posedge clk_i) disable iff (srst_i)
    st_r.pulse && !st_r.dir);

  reverse_c : cover property (@(posedge clk_i) disable iff (srst_i)
    st_r.pulse && st_r.dir ##[1:20] st_r.pulse && !st_r.dir);

  jump_c : cover property (@(posedge clk_i) disable iff (srst_i)
    now_state == st_r.prev + 2'h2);

endmodule

// ### hdl/qfd_consts.svh
`ifndef QFD_CONSTS_SVH
`define QFD_CONSTS_SVH

// ********************************************************
// Widths and counts.
// ********************************************************
`define QFD_CNT_W        16
`define QFD_HIST_W       4
`define QFD_STABLE_N     3
`define QFD_SYNC_N       2
`define QFD_LATENCY_MAX  7
`define QFD_CLK_PERIOD_NS 25

// ********************************************************
// Reset values.
// ********************************************************
`define QFD_CNT_RST      16'h0000
`define QFD_STATE_RST    2'h3

`endif

// ### hdl/qfd_pkg.sv
package qfd_pkg;

  // ********************************************************
  // Decoder step taken on one clock.
  // ********************************************************
  typedef enum logic [1:0]
  {
    QFD_HOLD = 2'b00,
    QFD_UP   = 2'b01,
    QFD_DOWN = 2'b10
  } qfd_step_type;

  // ********************************************************
  // State of one channel filter.
  // ********************************************************
  typedef struct packed
  {
    logic [3:0] hist;
    logic       level;
  } qfd_filt_type;

  // ********************************************************
  // State of the decoder and position counter.
  // ********************************************************
  typedef struct packed
  {
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  prev;
    logic        dir;
    logic        pulse;
    logic [15:0] count;
  } qfd_top_type;

endpackage

// ### hdl/qfd_filter.sv
`timescale 1ns/1ps
`include "qfd_consts.svh"

module qfd_filter
#(
  parameter int HIST_W   = `QFD_HIST_W,
  parameter int STABLE_N = `QFD_STABLE_N
)
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic sample_i,
  output logic      level_o
);

  qfd_pkg::qfd_filt_type st_r;
  qfd_pkg::qfd_filt_type st_nxt;

  // ********************************************************
  // History shift register and level decision.
  // ********************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.hist = {st_r.hist[HIST_W-2:0], sample_i};
    if (st_r.hist[STABLE_N-1:0] == {STABLE_N{1'b1}})
    begin
      st_nxt.level = 1'b1;
    end
    else if (st_r.hist[STABLE_N-1:0] == {STABLE_N{1'b0}})
    begin
      st_nxt.level = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;

  // ********************************************************
  // Checks.
  // ********************************************************
  hist_shift_a : assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) |-> st_r.hist[HIST_W-1:1] == $past(st_r.hist[HIST_W-2:0]))
    else $error("Filter history did not shift.");

  level_change_a : assert property (@(posedge clk_i) disable iff (srst_i)
    $changed(st_r.level) |-> $past(st_r.hist[STABLE_N-1:0]) == {STABLE_N{st_r.level}})
    else $error("Filter level changed without three equal samples.");

  glitch_reject_a : assert property (@(posedge clk_i) disable iff (srst_i)
    st_r.hist[STABLE_N-1:0] != {STABLE_N{~st_r.level}} |=> $stable(st_r.level))
    else $error("Filter passed a short pulse.");

  glitch_seen_c : cover property (@(posedge clk_i) disable iff (srst_i)
    st_r.hist[STABLE_N-1:0] == 3'b010 ##1 $stable(st_r.level));

endmodule

// ### test/qfd_encoder_model.sv
`timescale 1ns/1ps

// ********************************************************
// Encoder model that steps through the quadrature states.
// ********************************************************
module qfd_encoder_model
(
  input  wire logic clk_i,
  input  wire logic step_i,
  input  wire logic up_i,
  input  wire logic jump_i,
  input  wire logic spike_i,
  output logic      first_o,
  output logic      second_o
);
  logic [1:0] phase_r = 2'h0;
  logic [1:0] phase_nxt;

  // Phases 0 to 3 are states 4, 1, 2 and 3, so a rising phase has the first channel leading.
  function automatic logic [1:0] pin_pair(input logic [1:0] ph);
    case (ph)
      2'h0:    return 2'b00;
      2'h1:    return 2'b10;
      2'h2:    return 2'b11;
      default: return 2'b01;
    endcase
  endfunction

  always_comb
  begin
    phase_nxt = phase_r + (step_i ? (up_i ? 2'h1 : 2'h3) : 2'h0) + (jump_i ? 2'h2 : 2'h0);
  end

  initial
  begin
    first_o = 1'b0;
    second_o = 1'b0;
  end

  // A spike flips the first channel only while it is requested.
  always @(posedge clk_i)
  begin
    phase_r <= phase_nxt;
    {first_o, second_o} <= pin_pair(phase_nxt) ^ {spike_i, 1'b0};
  end
endmodule

// ### test/quadrature_filter_decoder_tb_top.sv
`timescale 1ns/1ps

module quadrature_filter_decoder_tb_top;
  typedef struct
  {
    logic [15:0] pos;
    logic        dir;
    realtime     t0;
  } qfd_note_type;

  logic         clk;
  logic         srst;
  logic         step;
  logic         up;
  logic         jump;
  logic         spike;
  logic         first;
  logic         second;
  logic         decode_count_pulse;
  logic         count_up;
  logic [15:0]  position;
  logic [7:0]   lfsr;
  logic [15:0]  exp_pos;
  logic [1:0]   ph;
  qfd_note_type q[$];
  qfd_note_type e;
  int           miscompares = 0;
  int           compares = 0;

  always #12.5 clk = ~clk;

  qfd_encoder_model enc_u (.clk_i(clk), .step_i(step), .up_i(up), .jump_i(jump), .spike_i(spike),
                           .first_o(first), .second_o(second));

  qfd_top dut_u (.clk_i(clk), .srst_i(srst), .encoder_input_first_i(first), .encoder_input_second_i(second),
                 .decode_count_pulse_o(decode_count_pulse), .count_up_o(count_up), .position_o(position));

  // ********************************************************
  // Shared tasks.
  // ********************************************************
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    compares++;
    if (seen !== expv)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic move(input logic dir, input int hold);
    @(posedge clk);
    step <= 1'b1;
    up <= dir;
    @(posedge clk);
    step <= 1'b0;
    exp_pos = dir ? exp_pos + 16'h0001 : exp_pos - 16'h0001;
    ph = dir ? ph + 2'h1 : ph + 2'h3;
    q.push_back('{pos: exp_pos, dir: dir, t0: $realtime});
    repeat (hold) @(posedge clk);
  endtask

  task automatic spike_for(input int len);
    @(posedge clk);
    spike <= 1'b1;
    repeat (len) @(posedge clk);
    spike <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (q.size() != 0 && n < 30)
    begin
      @(posedge clk);
      n++;
    end
    if (q.size() != 0)
    begin
      miscompares++;
      wrap_up();
    end
  endtask

  // ********************************************************
  // Output watcher.
  // ********************************************************
  always @(negedge clk)
  begin
    #2;
    if (!srst && decode_count_pulse === 1'b1)
    begin
      if (q.size() == 0)
        check(32'h0000_0001, 32'h0000_0000);
      else
      begin
        e = q.pop_front();
        check({16'h0000, position}, {16'h0000, e.pos});
        check({31'h0000_0000, count_up}, {31'h0000_0000, e.dir});
        check({31'h0000_0000, ($realtime - e.t0) <= 190.0}, 32'h0000_0001);
      end
      @(posedge clk);
      #1;
      check({31'h0000_0000, decode_count_pulse}, 32'h0000_0000);
    end
  end

  // ********************************************************
  // Main sequence.
  // ********************************************************
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    step = 1'b0;
    up = 1'b0;
    jump = 1'b0;
    spike = 1'b0;
    lfsr = 8'h2F;
    exp_pos = 16'h0000;
    ph = 2'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({16'h0000, position}, 32'h0000_0000);
    check({31'h0000_0000, count_up}, 32'h0000_0001);
    for (int i = 0; i < 48; i++)
    begin
      lfsr = lfsr_next(lfsr);
      move(lfsr[0], 4 + int'(lfsr[2:1]));
      if (lfsr[6:4] == 3'h0)
        spike_for(1 + int'(lfsr[3]));
    end
    drain();
    for (int i = 0; i < 8; i++)
      move(i < 4, 2);
    drain();
    @(posedge clk);
    jump <= 1'b1;
    @(posedge clk);
    jump <= 1'b0;
    ph = ph + 2'h2;
    repeat (12) @(posedge clk);
    while (ph != 2'h0)
      move(1'b1, 5);
    drain();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    exp_pos = 16'h0000;
    @(negedge clk);
    check({16'h0000, position}, 32'h0000_0000);
    check({31'h0000_0000, count_up}, 32'h0000_0001);
    for (int i = 0; i < 3; i++)
      move(1'b0, 5);
    drain();
    repeat (10) @(posedge clk);
    check(q.size(), 32'h0000_0000);
    wrap_up();
  end
endmodule
